// *** include/bdi_pkg.sv ***
// Shared constants, link states and request carrier for the dimmer serial slave port
package bdi_pkg;

  // Serial slave address, seven bits; arbitrary value
  localparam logic [6:0] BDI_DEV_ADDR = 7'h2a;

  // Register offsets
  localparam logic [7:0] BDI_TEST_OUTPUT_MUX_OFS = 8'h3a;
  localparam logic [7:0] BDI_PORT_STATUS_OFS = 8'h3b;

  // Reset values
  localparam logic [7:0] BDI_TEST_OUTPUT_MUX_RST = 8'h00;
  localparam logic [7:0] BDI_PORT_STATUS_RST = 8'h00;

  // Field position of test_output_select inside test_output_mux
  localparam int BDI_SEL_LSB = 0;
  localparam int BDI_SEL_MSB = 3;

  // Bits per byte on the wire
  localparam logic [3:0] BDI_BYTE_BITS = 4'h8;

  // Link side protocol states
  typedef enum logic [2:0] {
    BDI_IDLE,
    BDI_ADDR,
    BDI_ADDR_ACK,
    BDI_WR_BYTE,
    BDI_WR_ACK,
    BDI_RD_BYTE,
    BDI_RD_ACK
  } bdi_link_e;

  // One register access passed from the link to the register side
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } bdi_req_s;

endpackage

// *** core/bdi_i2c_slave.sv ***
// Two-wire serial slave port with register file for the lamp dimming controller
`timescale 1ns/1ps
`default_nettype none

module bdi_i2c_slave
  import bdi_pkg::*;
(
  // Core clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Link clock
  input wire logic link_clk_i,
  // Serial clock pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  // Serial data pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Test multiplexer select
  output logic [3:0] test_output_select_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State records
  typedef struct packed {
    logic [2:0] scl_s;     // Two sync stages plus history
    logic [2:0] sda_s;
    logic [2:0] ack_s;     // Answer toggle sync plus history
    bdi_link_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic first;
    logic rd;
    logic oe;
    logic lo;
    logic scl_oe;
    logic req_tgl;
    bdi_req_s req;
    logic [7:0] rdata;
  } bdi_lnk_s;

  typedef struct packed {
    logic [2:0] rq_s;      // Request toggle sync plus taken copy
    bdi_req_s [1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic busy;
    logic [7:0] mux;
    logic [7:0] wcount;
    logic [7:0] rdata;
    logic ack_tgl;
  } bdi_ref_s;
  bdi_lnk_s l_q, l_n;
  bdi_ref_s r_q, r_n;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: bus conditions
  logic scl_hi, scl_rise, scl_fall, sda_rise, sda_fall, start_c, stop_c;
  assign scl_hi = l_q.scl_s[1] & l_q.scl_s[2];
  assign scl_rise = l_q.scl_s[1] & ~l_q.scl_s[2];
  assign scl_fall = ~l_q.scl_s[1] & l_q.scl_s[2];
  assign sda_rise = l_q.sda_s[1] & ~l_q.sda_s[2];
  assign sda_fall = ~l_q.sda_s[1] & l_q.sda_s[2];
  assign start_c = scl_hi & sda_fall;
  assign stop_c = scl_hi & sda_rise;
  // Link protocol engine
  always_comb begin
    l_n = l_q;
    l_n.scl_s = {l_q.scl_s[1:0], scl_i};
    l_n.sda_s = {l_q.sda_s[1:0], sda_i};
    l_n.ack_s = {l_q.ack_s[1:0], r_q.ack_tgl};
    l_n.lo = 1'b0;
    l_n.scl_oe = 1'b0;
    // Answer word is stable once its toggle has crossed
    if (l_q.ack_s[1] != l_q.ack_s[2]) begin
      l_n.rdata = r_q.rdata;
    end
    unique case (l_q.st)
      BDI_IDLE: begin
      end
      BDI_ADDR: begin
        if (scl_rise) begin
          l_n.sh = {l_q.sh[6:0], l_q.sda_s[1]};
          l_n.cnt = l_q.cnt + 4'h1;
        end else if (scl_fall && l_q.cnt == BDI_BYTE_BITS) begin
          if (l_q.sh[7:1] == BDI_DEV_ADDR) begin
            l_n.oe = 1'b1;
            l_n.rd = l_q.sh[0];
            l_n.st = BDI_ADDR_ACK;
            if (l_q.sh[0]) begin
              l_n.req = '{we: 1'b0, addr: l_q.ptr, data: 8'h00};
              l_n.req_tgl = ~l_q.req_tgl;
            end
          end else begin
            l_n.st = BDI_IDLE;
          end
        end
      end
      BDI_ADDR_ACK: begin
        if (scl_fall) begin
          l_n.cnt = 4'h0;
          if (l_q.rd) begin
            l_n.sh = l_q.rdata;
            l_n.oe = ~l_q.rdata[7];
            l_n.ptr = l_q.ptr + 8'h01;
            l_n.st = BDI_RD_BYTE;
          end else begin
            l_n.oe = 1'b0;
            l_n.first = 1'b1;
            l_n.st = BDI_WR_BYTE;
          end
        end
      end
      BDI_WR_BYTE: begin
        if (scl_rise) begin
          l_n.sh = {l_q.sh[6:0], l_q.sda_s[1]};
          l_n.cnt = l_q.cnt + 4'h1;
        end else if (scl_fall && l_q.cnt == BDI_BYTE_BITS) begin
          l_n.oe = 1'b1;
          l_n.st = BDI_WR_ACK;
          if (l_q.first) begin
            l_n.ptr = l_q.sh;
          end else begin
            l_n.req = '{we: 1'b1, addr: l_q.ptr, data: l_q.sh};
            l_n.req_tgl = ~l_q.req_tgl;
            l_n.ptr = l_q.ptr + 8'h01;
          end
        end
      end
      BDI_WR_ACK: begin
        if (scl_fall) begin
          l_n.oe = 1'b0;
          l_n.cnt = 4'h0;
          l_n.first = 1'b0;
          l_n.st = BDI_WR_BYTE;
        end
      end
      BDI_RD_BYTE: begin
        if (scl_fall) begin
          if (l_q.cnt == BDI_BYTE_BITS - 4'h1) begin
            l_n.oe = 1'b0;
            l_n.cnt = 4'h0;
            l_n.st = BDI_RD_ACK;
          end else begin
            l_n.cnt = l_q.cnt + 4'h1;
            l_n.sh = {l_q.sh[6:0], 1'b0};
            l_n.oe = ~l_q.sh[6];
          end
        end
      end
      BDI_RD_ACK: begin
        if (scl_rise) begin
          if (l_q.sda_s[1]) begin
            l_n.st = BDI_IDLE;
          end else begin
            l_n.req = '{we: 1'b0, addr: l_q.ptr, data: 8'h00};
            l_n.req_tgl = ~l_q.req_tgl;
          end
        end else if (scl_fall) begin
          l_n.sh = l_q.rdata;
          l_n.oe = ~l_q.rdata[7];
          l_n.ptr = l_q.ptr + 8'h01;
          l_n.st = BDI_RD_BYTE;
        end
      end
    endcase
    // Bus conditions override any byte in progress
    if (start_c) begin
      l_n.st = BDI_ADDR;
      l_n.cnt = 4'h0;
      l_n.oe = 1'b0;
    end else if (stop_c) begin
      l_n.st = BDI_IDLE;
      l_n.oe = 1'b0;
    end
  end
  // Link domain registers
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      l_q <= '{scl_s: 3'h7, sda_s: 3'h7, st: BDI_IDLE, default: '0};
    end else begin
      l_q <= l_n;
    end
  end
  assign scl_o = l_q.lo;
  assign scl_oe_o = l_q.scl_oe;
  assign sda_o = l_q.lo;
  assign sda_oe_o = l_q.oe;
  ////////////////////////////////////////////////////////////////////////////
  // Core domain: request buffer and registers
  logic push, pop;
  bdi_req_s head;
  assign push = (r_q.rq_s[1] != r_q.rq_s[2]) && (r_q.cnt != 2'h2);
  assign pop = (r_q.cnt != 2'h0) && !r_q.busy;
  assign head = r_q.mem[r_q.rp];
  // Buffer fill, drain and register access
  always_comb begin
    r_n = r_q;
    r_n.rq_s[1:0] = {r_q.rq_s[0], l_q.req_tgl};
    r_n.busy = pop; // Drain stalls one cycle after each access
    if (push) begin
      r_n.rq_s[2] = r_q.rq_s[1]; // Full buffer holds the request pending
      r_n.mem[r_q.wp] = l_q.req;
      r_n.wp = ~r_q.wp;
    end
    if (pop) begin
      r_n.rp = ~r_q.rp;
      r_n.ack_tgl = ~r_q.ack_tgl;
      if (head.we) begin
        r_n.wcount = r_q.wcount + 8'h01;
        if (head.addr == BDI_TEST_OUTPUT_MUX_OFS) begin
          r_n.mux = head.data;
        end
      end
      if (head.addr == BDI_TEST_OUTPUT_MUX_OFS) begin
        r_n.rdata = r_n.mux;
      end else if (head.addr == BDI_PORT_STATUS_OFS) begin
        r_n.rdata = r_n.wcount;
      end else begin
        r_n.rdata = 8'h00;
      end
    end
    r_n.cnt = r_q.cnt + {1'b0, push} - {1'b0, pop};
  end
  // Core domain registers
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_q <= '{mux: BDI_TEST_OUTPUT_MUX_RST, wcount: BDI_PORT_STATUS_RST, default: '0};
    end else begin
      r_q <= r_n;
    end
  end

  assign test_output_select_o = r_q.mux[BDI_SEL_MSB:BDI_SEL_LSB];
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_addr_byte_done;
    l_q.st == BDI_ADDR && scl_fall && l_q.cnt == BDI_BYTE_BITS;
  endsequence
  sequence s_own_addr;
    l_q.sh[7:1] == BDI_DEV_ADDR;
  endsequence
  a_pins_low_only: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    !sda_o && !scl_o && !scl_oe_o)
    else $error("serial pin driven other than low");
  a_start_seen: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    start_c |=> l_q.st == BDI_ADDR && l_q.cnt == 4'h0 && !sda_oe_o)
    else $error("start not taken");
  a_stop_seen: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    stop_c && !start_c |=> l_q.st == BDI_IDLE && !sda_oe_o)
    else $error("stop not taken");
  a_data_change_low: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    $changed(sda_oe_o) && !$past(start_c) && !$past(stop_c) |-> !$past(l_q.scl_s[1]))
    else $error("data changed while clock high");
  a_addr_ack: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    s_addr_byte_done and s_own_addr |=> sda_oe_o && l_q.st == BDI_ADDR_ACK)
    else $error("own address not acknowledged");
  a_ack_hold: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    l_q.st == BDI_WR_ACK |-> sda_oe_o)
    else $error("acknowledge released early");
  a_msb_first: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    l_q.st == BDI_RD_BYTE |-> sda_oe_o == ~l_q.sh[7])
    else $error("read bit not msb of shift");
  a_next_byte: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    l_q.st == BDI_WR_ACK && scl_fall && !start_c && !stop_c |=>
      l_q.st == BDI_WR_BYTE && l_q.cnt == 4'h0)
    else $error("transfer cut after byte");
  a_ptr_advance: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    $changed(l_q.req_tgl) && l_q.req.we |-> l_q.ptr == $past(l_q.ptr) + 8'h01)
    else $error("register address not advanced");
  a_mux_write: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    pop && head.we && head.addr == BDI_TEST_OUTPUT_MUX_OFS |=>
      r_q.mux == $past(head.data) ##1 test_output_select_o == $past(r_q.mux[3:0]))
    else $error("mux write lost");
endmodule // bdi_i2c_slave

`default_nettype wire

// *** testbench/bdi_master.sv ***
// Serial bus master model that drives the open-drain clock and data lines
`timescale 1ns/1ps
`default_nettype none

module bdi_master (
  // Core clock and sensed data line
  input wire logic clk_i,
  input wire logic sda_i,
  // Pull-down requests, high pulls the line low
  output logic scl_pull_o,
  output logic sda_pull_o
);
  // Quarter of a serial clock period in core clocks
  localparam int QTR = 250;
  int n_glitch;

  // Lines released until the first transfer
  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
    n_glitch = 0;
  end

  // Wait a number of core clocks
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Data falls while the clock is high
  task automatic start();
    sda_pull_o <= 1'b1;
    wt(QTR);
    scl_pull_o <= 1'b1;
    wt(QTR);
  endtask

  // Data rises while the clock is high, always before the next start
  task automatic stop();
    sda_pull_o <= 1'b1;
    wt(QTR);
    scl_pull_o <= 1'b0;
    wt(QTR);
    sda_pull_o <= 1'b0;
    wt(QTR);
  endtask

  // One bit: data set while clock low, sampled twice while high
  task automatic bit_io(input logic d, output logic q);
    logic q1;
    sda_pull_o <= ~d;
    wt(QTR);
    scl_pull_o <= 1'b0;
    wt(QTR);
    q1 = sda_i;
    wt(QTR);
    q = sda_i;
    if (q !== q1) n_glitch++;
    scl_pull_o <= 1'b1;
    wt(QTR);
  endtask

  // Eight bits msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(a, ak);
  endtask
endmodule // bdi_master

`default_nettype wire

// *** testbench/backlight_dimmer_i2c_slave_test.sv ***
// Testbench for the dimmer serial slave port
`timescale 1ns/1ps
`default_nettype none

module backlight_dimmer_i2c_slave_test;
  import bdi_pkg::*;
  logic ref_clk_i, rstn_i, link_clk;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o, scl_pull, sda_pull, ak;
  logic [3:0] sel;
  logic [7:0] rd;
  int n_fail, n_compared;
  wire logic scl_w, sda_w;

  // Open-drain lines with pull-ups
  assign scl_w = ~(scl_pull | (scl_oe_o & ~scl_o));
  assign sda_w = ~(sda_pull | (sda_oe_o & ~sda_o));

  bdi_i2c_slave uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link_clk_i(link_clk),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .test_output_select_o(sel));
  bdi_master m (.clk_i(ref_clk_i), .sda_i(sda_w), .scl_pull_o(scl_pull),
    .sda_pull_o(sda_pull));

  // Core clock, 4 ns
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // Link clock, 160 ns, offset in phase
  initial begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end

  // Compare one bit
  task automatic cmp_bit(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %b", $time, msg, got);
    end
  endtask

  // Compare one byte
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Send one byte and check the slave's acknowledge
  task automatic wb(input logic [7:0] d, input logic exp_ak);
    m.xfer(d, 1'b1, rd, ak);
    cmp_bit(ak, exp_ak, "ack");
  endtask

  // Print counts and verdict, then end
  task automatic test_done();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog, ten bytes at 36 us each plus framing come to about 382 us
  initial begin
    #400us;
    n_fail++;
    test_done();
  end

  // Main sequence
  initial begin
    n_fail = 0;
    n_compared = 0;
    rstn_i = 1'b0;
    repeat (3) @(posedge link_clk);
    @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    m.wt(300);
    cmp_byte({4'h0, sel}, BDI_TEST_OUTPUT_MUX_RST, "select reset");
    // Foreign address is not acknowledged, master aborts
    m.start();
    wb({BDI_DEV_ADDR + 7'h1, 1'b0}, 1'b1);
    m.stop();
    // Index, then two data bytes; second lands on the read-only next register
    m.start();
    wb({BDI_DEV_ADDR, 1'b0}, 1'b0);
    wb(BDI_TEST_OUTPUT_MUX_OFS, 1'b0);
    wb(8'h05, 1'b0);
    wb(8'h09, 1'b0);
    m.stop();
    m.wt(20);
    cmp_byte({4'h0, sel}, 8'h05, "select");
    // Point at the mux register, then read it back
    m.start();
    wb({BDI_DEV_ADDR, 1'b0}, 1'b0);
    wb(BDI_TEST_OUTPUT_MUX_OFS, 1'b0);
    m.stop();
    m.start();
    wb({BDI_DEV_ADDR, 1'b1}, 1'b0);
    m.xfer(8'hff, 1'b0, rd, ak);
    cmp_byte(rd, 8'h05, "read data");
    // Master acknowledge asks for the next register, the count of written bytes
    m.xfer(8'hff, 1'b1, rd, ak);
    cmp_byte(rd, BDI_PORT_STATUS_RST + 8'h02, "status read");
    cmp_bit(ak, 1'b1, "released at master nack");
    m.stop();
    cmp_bit(sda_oe_o, 1'b0, "data released");
    cmp_bit(scl_oe_o, 1'b0, "clock never driven");
    cmp_byte(8'(m.n_glitch), 8'h00, "data moved while clock high");
    test_done();
  end
endmodule // backlight_dimmer_i2c_slave_test

`default_nettype wire
